// [rtl/dbs_sequencer.sv]
// burst dma state sequencer: paces word bursts between buffer and host master
`timescale 1ns/1ps
`default_nettype none
module dbs_sequencer (
	input  wire logic                          i_clk_sys,
	input  wire logic                          i_reset_n,
	input  wire logic                          i_sync_reset,
	input  wire dbs_pkg::dbs_cause_s           i_cause,
	input  wire dbs_pkg::dbs_pace_s            i_pace,
	input  wire logic                          i_total_load,
	input  wire logic [dbs_pkg::TOTAL_W-1:0]   i_total_count,
	input  wire logic                          i_host_dma_acknowledge_n,
	output logic                               o_host_dma_request_n,
	output logic                               o_word_transfer_strobe,
	output logic                               o_terminal_count,
	output logic                               o_busy,
	output logic                               o_sequencer_state_bit_c
);

	dbs_pkg::dbs_state_e                state_r;
	logic [dbs_pkg::TICK_CNT_W-1:0]     tick_cnt_r;
	logic                               tick_r;
	logic                               ack_meta_r;
	logic                               ack_sync_r;
	logic                               cause_d_r;
	logic                               start_pend_r;
	logic                               req_en_r;
	logic                               req_en_fb_r;
	logic [dbs_pkg::BURST_W-1:0]        burst_cnt_r;
	logic [dbs_pkg::DELAY_W-1:0]        delay_cnt_r;
	logic [dbs_pkg::TOTAL_W-1:0]        total_cnt_r;
	logic                               cause_any;
	logic                               ack;
	logic                               burst_out;
	logic                               word_go;

	localparam logic [dbs_pkg::TICK_CNT_W-1:0] TICK_LAST =
		dbs_pkg::TICK_CNT_W'(dbs_pkg::SEQ_TICK_CYC - 1);

	// every check below runs on the system clock and sleeps through async reset
	default clocking dbs_cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);

	assign cause_any = i_cause.boot_rom_read | i_cause.disk_read_done
		| i_cause.disk_write_pending;
	assign ack = ~ack_sync_r;
	assign burst_out = (burst_cnt_r == dbs_pkg::BURST_RST); // high once burst is spent
	// a word moves on an acknowledged tick while both counts remain
	assign word_go = tick_r && (state_r == dbs_pkg::DBS_S4) && ack && !burst_out
		&& (total_cnt_r != dbs_pkg::TOTAL_RST); // R09

	// 2 MHz tick from the 20 MHz clock; one pulse keeps every stage in step
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tick_cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (tick_cnt_r == TICK_LAST); // R01
			tick_cnt_r <= (tick_cnt_r == TICK_LAST) ? '0 : tick_cnt_r + 1'b1;
		end
	end

	// acknowledge pin crosses in from the host: two flops before use
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ack_meta_r <= 1'b1;
			ack_sync_r <= 1'b1;
		end else begin
			ack_meta_r <= i_host_dma_acknowledge_n;
			ack_sync_r <= ack_meta_r;
		end
	end

	// start pulse on any new cause; held until the idle sequencer takes it
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cause_d_r <= 1'b0;
			start_pend_r <= 1'b0;
		end else begin
			cause_d_r <= cause_any;
			if (cause_any && !cause_d_r) begin
				start_pend_r <= 1'b1; // R02
			end else if (i_sync_reset || (tick_r && state_r == dbs_pkg::DBS_S0)) begin
				start_pend_r <= 1'b0;
			end
		end
	end

	// request enable: set by start, fed back and sampled on the next tick
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			req_en_r <= 1'b0;
			req_en_fb_r <= 1'b0;
		end else if (i_sync_reset || o_terminal_count) begin
			req_en_r <= 1'b0;
			req_en_fb_r <= 1'b0;
		end else begin
			if (start_pend_r && state_r == dbs_pkg::DBS_S0) begin
				req_en_r <= 1'b1; // R16
			end
			if (tick_r) begin
				req_en_fb_r <= req_en_r; // R16
			end
		end
	end

	// state sequencer; waits in 4 and 5 stand for the inhibited count enable
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_r <= dbs_pkg::DBS_S0;
		end else if (i_sync_reset) begin
			state_r <= dbs_pkg::DBS_S0; // R17
		end else if (tick_r) begin
			unique case (state_r)
				dbs_pkg::DBS_S0: begin
					if (start_pend_r) begin
						state_r <= dbs_pkg::DBS_S1; // R05 R06
					end
				end
				dbs_pkg::DBS_S1: begin
					state_r <= dbs_pkg::DBS_S2;
				end
				dbs_pkg::DBS_S2: begin
					state_r <= dbs_pkg::DBS_S3; // R07
				end
				dbs_pkg::DBS_S3: begin
					state_r <= dbs_pkg::DBS_S4; // R08
				end
				dbs_pkg::DBS_S4: begin
					if (total_cnt_r == dbs_pkg::TOTAL_RST) begin
						state_r <= dbs_pkg::DBS_S0; // R15
					end else if (burst_out) begin
						state_r <= dbs_pkg::DBS_S5; // R10 R11
					end
				end
				dbs_pkg::DBS_S5: begin
					if (delay_cnt_r == dbs_pkg::DELAY_RST) begin
						state_r <= dbs_pkg::DBS_S6; // R12
					end
				end
				dbs_pkg::DBS_S6: begin
					state_r <= dbs_pkg::DBS_S2; // R13 R14
				end
			endcase
		end
	end

	// burst counter: gated and loaded in state 2, counted down by word strobes
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			burst_cnt_r <= dbs_pkg::BURST_RST;
		end else if (i_sync_reset) begin
			burst_cnt_r <= dbs_pkg::BURST_RST;
		end else if (tick_r && state_r == dbs_pkg::DBS_S2) begin
			burst_cnt_r <= i_pace.burst_len; // R04 R07
		end else if (word_go) begin
			burst_cnt_r <= burst_cnt_r - 1'b1; // R09
		end
	end

	// delay counter: reloaded on every tick in state 4, runs out in state 5
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			delay_cnt_r <= dbs_pkg::DELAY_RST;
		end else if (i_sync_reset) begin
			delay_cnt_r <= dbs_pkg::DELAY_RST;
		end else if (tick_r && state_r == dbs_pkg::DBS_S4) begin
			delay_cnt_r <= i_pace.delay_len; // R04
		end else if (tick_r && state_r == dbs_pkg::DBS_S5
			&& delay_cnt_r != dbs_pkg::DELAY_RST) begin
			delay_cnt_r <= delay_cnt_r - 1'b1; // R12
		end
	end

	// total word counter; the host loads it, a load wins over a word
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			total_cnt_r <= dbs_pkg::TOTAL_RST;
		end else if (i_total_load) begin
			total_cnt_r <= i_total_count; // R03
		end else if (word_go) begin
			total_cnt_r <= total_cnt_r - 1'b1;
		end
	end

	// outputs, all registered
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_host_dma_request_n <= 1'b1;
			o_word_transfer_strobe <= 1'b0;
			o_terminal_count <= 1'b0;
			o_busy <= 1'b0;
			o_sequencer_state_bit_c <= 1'b0;
		end else if (i_sync_reset) begin
			o_host_dma_request_n <= 1'b1; // R17
			o_word_transfer_strobe <= 1'b0; // R17
			o_terminal_count <= 1'b0;
			o_busy <= 1'b0;
			o_sequencer_state_bit_c <= 1'b0;
		end else begin
			// request stays up through the burst, dropped one clock after it is spent
			o_host_dma_request_n <= !(req_en_fb_r && !burst_out
				&& (state_r == dbs_pkg::DBS_S3 || state_r == dbs_pkg::DBS_S4)
				&& total_cnt_r != dbs_pkg::TOTAL_RST); // R08
			o_word_transfer_strobe <= word_go; // R09
			o_terminal_count <= tick_r && state_r == dbs_pkg::DBS_S4
				&& total_cnt_r == dbs_pkg::TOTAL_RST; // R15
			o_busy <= (state_r != dbs_pkg::DBS_S0);
			o_sequencer_state_bit_c <= (state_r == dbs_pkg::DBS_S4)
				|| (state_r == dbs_pkg::DBS_S5) || (state_r == dbs_pkg::DBS_S6);
		end
	end

	a_tick_period: assert property (tick_r |=> !tick_r [*8] ##1 !tick_r ##1 tick_r) // R01
		else $error("sequencer tick is not every ten clocks");
	a_state_moves_tick: assert property (!tick_r && !i_sync_reset |=> $stable(state_r)) // R01
		else $error("state changed off the tick");
	a_start_cause: assert property ($rose(start_pend_r) |-> $past(cause_any)
		&& !$past(cause_any, 2)) // R02
		else $error("start pending without a new cause");
	a_idle_to_one: assert property (tick_r && state_r == dbs_pkg::DBS_S0 && start_pend_r
		&& !i_sync_reset |=> state_r == dbs_pkg::DBS_S1) // R06
		else $error("idle did not step to state one");
	a_burst_load: assert property (tick_r && state_r == dbs_pkg::DBS_S2 && !i_sync_reset
		|=> burst_cnt_r == $past(i_pace.burst_len)) // R07
		else $error("burst counter not loaded in state two");
	a_req_state: assert property (!o_host_dma_request_n |-> $past(state_r) inside
		{dbs_pkg::DBS_S3, dbs_pkg::DBS_S4}) // R08
		else $error("request outside states three and four");
	a_strobe_cause: assert property (o_word_transfer_strobe |-> $past(ack)
		&& $past(state_r) == dbs_pkg::DBS_S4) // R09
		else $error("word strobe without acknowledge in state four");
	a_hold_four: assert property (tick_r && state_r == dbs_pkg::DBS_S4 && !burst_out
		&& total_cnt_r != dbs_pkg::TOTAL_RST && !i_sync_reset
		|=> state_r == dbs_pkg::DBS_S4) // R10
		else $error("state four left with burst remaining");
	a_five_wait: assert property (tick_r && state_r == dbs_pkg::DBS_S5
		&& delay_cnt_r != dbs_pkg::DELAY_RST && !i_sync_reset
		|=> state_r == dbs_pkg::DBS_S5) // R12
		else $error("state five left before delay expired");
	a_six_reload: assert property (tick_r && state_r == dbs_pkg::DBS_S6 && !i_sync_reset
		|=> state_r == dbs_pkg::DBS_S2) // R13
		else $error("state six did not return to two");
	a_term_count: assert property (o_terminal_count |=> state_r == dbs_pkg::DBS_S0
		|| $past(i_sync_reset)) // R15
		else $error("terminal count without return to idle");
	a_sync_reset: assert property (i_sync_reset |=> state_r == dbs_pkg::DBS_S0
		&& o_host_dma_request_n && !o_word_transfer_strobe) // R17
		else $error("synchronous reset did not idle the block");

	c_full_burst: cover property (state_r == dbs_pkg::DBS_S6 ##[1:40] state_r == dbs_pkg::DBS_S2);
	c_word_moved: cover property (o_word_transfer_strobe);
	c_terminal: cover property (o_terminal_count);

endmodule
`default_nettype wire

// [rtl/dbs_pkg.sv]
// package for the burst dma state sequencer: constants, states, carriers
// Overview of operation
// (R01) all pacing logic steps on one 2 MHz tick
// (R02) start on boot read, read done, write
// (R03) host loads total word count before start
// (R04) burst counter sizes bursts, delay counter pauses
// (R05) start is taken only in idle state zero
// (R06) next tick moves idle to state one
// (R07) state two loads and gates burst counter
// (R08) state three raises active-low dma request
// (R09) acknowledged tick in state four strobes one word
// (R10) state four holds while burst count remains
// (R11) burst exhausted re-enables counting, enters state five
// (R12) state five stalls until programmed delay expires
// (R13) state six loads sequencer back to two
// (R14) leaving state six restores count enable
// (R15) total count exhausted signals terminal count
// (R16) start sets enable, sampled next tick
// (R17) synchronous reset returns idle, request off
package dbs_pkg;

	// system clock period and the sequencer tick period, in ns
	localparam int SYS_CLK_NS = 50;
	localparam int SEQ_TICK_NS = 500;
	localparam int SEQ_TICK_CYC = (SEQ_TICK_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int TICK_CNT_W = 4;

	// counter widths and reset values
	localparam int BURST_W = 8;
	localparam int DELAY_W = 8;
	localparam int TOTAL_W = 16;
	localparam logic [BURST_W-1:0] BURST_RST = 8'h00;
	localparam logic [DELAY_W-1:0] DELAY_RST = 8'h00;
	localparam logic [TOTAL_W-1:0] TOTAL_RST = 16'h0000;

	// sequencer states, one-hot
	typedef enum logic [6:0] {
		DBS_S0 = 7'h01,
		DBS_S1 = 7'h02,
		DBS_S2 = 7'h04,
		DBS_S3 = 7'h08,
		DBS_S4 = 7'h10,
		DBS_S5 = 7'h20,
		DBS_S6 = 7'h40
	} dbs_state_e;

	// host-programmed pacing figures, held steady by the host
	typedef struct packed {
		logic [BURST_W-1:0] burst_len;
		logic [DELAY_W-1:0] delay_len;
	} dbs_pace_s;

	// causes that open a dma cycle
	typedef struct packed {
		logic boot_rom_read;
		logic disk_read_done;
		logic disk_write_pending;
	} dbs_cause_s;

endpackage

// [verif/dbs_host_model.sv]
// host bus master model: answers the dma request with an acknowledge
`timescale 1ns/1ps
`default_nettype none
module dbs_host_model (
	input  wire logic       i_clk_sys,
	input  wire logic       i_reset_n,
	input  wire logic       i_host_dma_request_n,
	input  wire logic [7:0] i_ack_delay,
	output logic            o_host_dma_acknowledge_n
);
	logic [7:0] wait_r;
	// count clocks of a standing request; a slow host holds acknowledge off longer
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wait_r <= 8'h00;
			o_host_dma_acknowledge_n <= 1'b1;
		end else if (i_host_dma_request_n) begin
			wait_r <= 8'h00;
			o_host_dma_acknowledge_n <= 1'b1;
		end else begin
			wait_r <= (wait_r == 8'hff) ? wait_r : wait_r + 8'h01;
			o_host_dma_acknowledge_n <= (wait_r + 8'h01 < i_ack_delay);
		end
	end
endmodule
`default_nettype wire

// [verif/dbs_sequencer_bench.sv]
// self-checking bench for the burst dma state sequencer
`timescale 1ns/1ps
`default_nettype none
module dbs_sequencer_bench;
	logic                        clk = 1'b0;
	logic                        rst_n = 1'b0;
	logic                        sync_rst = 1'b0;
	dbs_pkg::dbs_cause_s         cause = '0;
	dbs_pkg::dbs_pace_s          pace = '0;
	logic                        tot_ld = 1'b0;
	logic [dbs_pkg::TOTAL_W-1:0] tot = '0;
	logic [7:0]                  ack_dly = 8'h01;
	wire                         ack_n;
	wire                         req_n;
	wire                         strobe;
	wire                         tc;
	wire                         busy;
	wire                         bit_c;
	int                          err_total = 0;
	int                          comparisons = 0;
	int                          cyc = 0;
	int                          n_strobe = 0;
	int                          req_fall = 0;
	int                          ack_hi = 0;
	logic                        req_q = 1'b1;
	always #25 clk = ~clk;
	dbs_sequencer dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_sync_reset(sync_rst),
		.i_cause(cause), .i_pace(pace), .i_total_load(tot_ld), .i_total_count(tot),
		.i_host_dma_acknowledge_n(ack_n), .o_host_dma_request_n(req_n),
		.o_word_transfer_strobe(strobe), .o_terminal_count(tc), .o_busy(busy),
		.o_sequencer_state_bit_c(bit_c));
	dbs_host_model host (.i_clk_sys(clk), .i_reset_n(rst_n), .i_host_dma_request_n(req_n),
		.i_ack_delay(ack_dly), .o_host_dma_acknowledge_n(ack_n));
	// bookkeeping of strobes and request edges; a strobe long after ack left is a fault
	always @(posedge clk) begin
		cyc <= cyc + 1;
		req_q <= req_n;
		ack_hi <= (ack_n === 1'b0) ? 0 : ack_hi + 1;
		if (strobe === 1'b1) n_strobe <= n_strobe + 1;
		if (req_q === 1'b1 && req_n === 1'b0) req_fall <= cyc;
		if (strobe === 1'b1 && ack_hi > 4) cmp_cnt("strobe_without_ack", 0, ack_hi);
	end
	task automatic cmp_bit(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic cmp_cnt(input string what, input int exp, input int got);
		comparisons++;
		if (got != exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	// sel 0 strobe, 1 terminal count, 2 busy; at stays -1 when the limit runs out
	task automatic wait_sig(input int sel, input int lim, output int at);
		logic s;
		at = -1;
		for (int i = 0; i < lim && at < 0; i++) begin
			@(negedge clk);
			s = (sel == 0) ? strobe : (sel == 1) ? tc : busy;
			if (s === 1'b1) at = cyc;
		end
	endtask
	task automatic start_xfer(input logic [15:0] n, input logic [7:0] bl,
		input logic [7:0] dl, input int c);
		@(posedge clk);
		tot <= n;
		tot_ld <= 1'b1;
		pace <= dbs_pkg::dbs_pace_s'({bl, dl});
		@(posedge clk);
		tot_ld <= 1'b0;
		cause <= dbs_pkg::dbs_cause_s'(3'h1 << c);
		@(posedge clk);
		cause <= '0;
	endtask
	task automatic t_causes();
		int at;
		int base;
		for (int c = 0; c < 3; c++) begin
			base = n_strobe;
			start_xfer(16'h0001, 8'h01, 8'h00, c);
			wait_sig(2, 14, at);
			cmp_bit("busy_after_cause", 1'b1, at >= 0);
			wait_sig(1, 300, at);
			cmp_bit("terminal_count", 1'b1, at >= 0);
			cmp_cnt("words_moved", 1, n_strobe - base);
			repeat (2) @(negedge clk);
			cmp_bit("idle_after_tc", 1'b0, busy);
		end
		$display("test causes done");
	endtask
	task automatic t_burst();
		int t[5];
		int at;
		int base;
		int t0;
		ack_dly <= 8'h01;
		base = n_strobe;
		t0 = cyc;
		start_xfer(16'h0005, 8'h03, 8'h02, 2);
		for (int k = 0; k < 5; k++) wait_sig(0, 400, t[k]);
		cmp_bit("request_seen", 1'b1, req_fall > t0);
		cmp_cnt("gap_in_burst_1", 10, t[1] - t[0]);
		cmp_cnt("gap_in_burst_2", 10, t[2] - t[1]);
		cmp_bit("delay_between_bursts", 1'b1, t[3] - t[2] >= 50);
		cmp_cnt("gap_next_burst", 10, t[4] - t[3]);
		wait_sig(1, 400, at);
		cmp_bit("burst_tc", 1'b1, at >= 0);
		cmp_cnt("burst_words", 5, n_strobe - base);
		$display("test burst done");
	endtask
	task automatic t_slow();
		int at;
		ack_dly <= 8'h28;
		start_xfer(16'h0002, 8'h02, 8'h00, 0);
		wait_sig(0, 600, at);
		cmp_bit("slow_first_strobe", 1'b1, at - req_fall >= 40);
		cmp_bit("state_c_in_burst", 1'b1, bit_c);
		wait_sig(1, 600, at);
		cmp_bit("slow_tc", 1'b1, at >= 0);
		$display("test slow done");
	endtask
	task automatic t_sync();
		int at;
		ack_dly <= 8'h01;
		start_xfer(16'h0008, 8'h04, 8'h00, 1);
		wait_sig(0, 300, at);
		@(posedge clk);
		sync_rst <= 1'b1;
		@(posedge clk);
		sync_rst <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		cmp_bit("sync_request_off", 1'b1, req_n);
		cmp_bit("sync_idle", 1'b0, busy);
		wait_sig(0, 60, at);
		cmp_cnt("sync_no_strobe", -1, at);
		$display("test sync done");
	endtask
	task automatic end_sim();
		$display("counts: %0d comparisons, %0d mismatches", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// watchdog well beyond the several hundred clocks the tests need
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		end_sim();
	end
	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk);
		cmp_bit("reset_request", 1'b1, req_n);
		cmp_bit("reset_strobe", 1'b0, strobe);
		cmp_bit("reset_busy", 1'b0, busy);
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		$display("test reset done");
		t_causes();
		t_burst();
		t_slow();
		t_sync();
		end_sim();
	end
endmodule
`default_nettype wire
